// *** inc/lws_pkg.sv ***
// Package with widths, encodings and carrier types for the late-write SRAM core.
package lws_pkg;
    localparam int LWS_ADDR_W = 10;
    localparam int LWS_LANE_W = 9;
    localparam int LWS_LANES = 4;
    localparam int LWS_DATA_W = LWS_LANE_W * LWS_LANES;
    localparam int LWS_DEPTH = 1 << LWS_ADDR_W;
    localparam logic [LWS_LANES-1:0] LWS_NO_LANE = 4'h0;
    localparam logic [LWS_DATA_W-1:0] LWS_DATA_ZERO = 36'h0;
    localparam logic [LWS_ADDR_W-1:0] LWS_ADDR_ZERO = 10'h0;
    localparam real LWS_CLK_PERIOD_NS = 4.0;

    // Cycle kinds decoded from the sampled controls.
    typedef enum logic [1:0]
    {
        LWS_DESEL = 2'b00,
        LWS_READ = 2'b01,
        LWS_WRITE = 2'b11,
        LWS_NOP_WRITE = 2'b10
    } lws_cycle_t;

    // Controls sampled together with the address.
    typedef struct packed
    {
        logic select_n;
        logic sync_write_n;
        logic [LWS_LANES-1:0] byte_lane_we_n;
        logic [LWS_ADDR_W-1:0] addr;
    } lws_req_t;

    // Pending late write held in the one-entry buffer.
    typedef struct packed
    {
        logic valid;
        logic [LWS_LANES-1:0] lanes;
        logic [LWS_ADDR_W-1:0] addr;
        logic [LWS_DATA_W-1:0] data;
    } lws_wbuf_t;
endpackage

// *** rtl/lws_lane_merge.sv ***
// One nine-bit lane merge: picks buffered write data over array data.
`timescale 1ns/1ns
module lws_lane_merge
    import lws_pkg::*;
(
    // Lane data
    input wire logic [LWS_LANE_W-1:0] array_in,
    input wire logic [LWS_LANE_W-1:0] buffer_in,
    // Select
    input wire logic use_buffer_in,
    // Result
    output logic [LWS_LANE_W-1:0] lane_out
);
    always_comb
    begin
        lane_out = use_buffer_in ? buffer_in : array_in;
    end
endmodule

// *** rtl/lws_sram_core.sv ***
// Late-write synchronous SRAM core with pipelined reads and byte-lane writes.
//
// Operation
// RL1: Selects, write and byte enables and address are captured only on rising clock.
// RL2: Read sampled on one edge loads output register on the next edge.
// RL3: A new read address is accepted while previous read data is output.
// RL4: Controller inserts a deselect cycle before any write following a read.
// RL5: A read may directly follow a write with no idle cycle.
// RL6: Deselect sampled turns output drivers off after the next rising edge.
// RL7: Write enable sampled low turns output drivers off in that cycle.
// RL8: Each byte lane is nine bits with its own write enable.
// RL9: Byte write enables are registered alongside the write enable.
// RL10: Byte enables are ignored on reads; all lanes are returned.
// RL11: Write with all byte enables active writes the full word.
// RL12: A write to any lane suppresses reading of every lane that cycle.
// RL13: Write with no lane enabled neither writes nor reads, yet disables outputs.
// RL14: Write address taken on one edge, its data on the following edge.
// RL15: Each late write waits in a one-entry buffer until committed.
// RL16: Reads matching the buffered write address return buffered data.
// RL17: Read is select and no write; write both active; deselect select inactive.
`timescale 1ns/1ns
module lws_sram_core
    import lws_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Request pins
    input wire logic [LWS_ADDR_W-1:0] addr_in,
    input wire logic select_n_in,
    input wire logic sync_write_n_in,
    input wire logic [LWS_LANES-1:0] byte_lane_we_n_in,
    // Data bus
    input wire logic [LWS_DATA_W-1:0] data_in,
    output logic [LWS_DATA_W-1:0] data_out,
    output logic data_oe_out
);
    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    lws_req_t req;
    lws_req_t next_req;
    lws_cycle_t cyc;
    lws_cycle_t next_cyc;

    always_comb
    begin
        next_req.select_n = select_n_in; // see RL1
        next_req.sync_write_n = sync_write_n_in;
        next_req.byte_lane_we_n = byte_lane_we_n_in; // see RL9
        next_req.addr = addr_in;
        if (select_n_in) // see RL17
        begin
            next_cyc = LWS_DESEL;
        end
        else if (sync_write_n_in)
        begin
            next_cyc = LWS_READ;
        end
        else if (byte_lane_we_n_in == ~LWS_NO_LANE)
        begin
            next_cyc = LWS_NOP_WRITE; // see RL13
        end
        else
        begin
            next_cyc = LWS_WRITE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            req <= '{select_n: 1'b1, sync_write_n: 1'b1, byte_lane_we_n: ~LWS_NO_LANE, addr: LWS_ADDR_ZERO};
            cyc <= LWS_DESEL;
        end
        else
        begin
            req <= next_req;
            cyc <= next_cyc;
        end
    end

    // ------------------------------------------------------------
    // Write buffer and array
    // ------------------------------------------------------------
    logic [LWS_DATA_W-1:0] mem [LWS_DEPTH];
    lws_wbuf_t wbuf;
    lws_wbuf_t next_wbuf;
    logic commit;
    logic wr_taken;
    logic [LWS_LANES-1:0] lane_wr;

    // Data for the write sampled last edge arrives on this edge.
    assign wr_taken = (cyc == LWS_WRITE); // see RL14

    always_comb
    begin
        next_wbuf = wbuf;
        commit = 1'b0;
        if (wr_taken)
        begin
            // The older entry moves to the array as the new one takes its place.
            commit = wbuf.valid; // see RL15
            next_wbuf.valid = 1'b1;
            next_wbuf.lanes = ~req.byte_lane_we_n; // see RL11
            next_wbuf.addr = req.addr;
            next_wbuf.data = data_in; // see RL14
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wbuf <= '{valid: 1'b0, lanes: LWS_NO_LANE, addr: LWS_ADDR_ZERO, data: LWS_DATA_ZERO};
        end
        else
        begin
            wbuf <= next_wbuf;
        end
    end

    // Lane strobes for the commit; lanes the write left out keep their array value.
    always_comb
    begin
        lane_wr = LWS_NO_LANE;
        if (commit)
        begin
            lane_wr = wbuf.lanes; // see RL8
        end
    end

    // Array has no reset; lane-wise commit of the buffered entry.
    always_ff @(posedge clk_sys_in)
    begin
        for (int i = 0; i < LWS_LANES; i++)
        begin
            if (lane_wr[i]) // see RL8
            begin
                mem[wbuf.addr][i*LWS_LANE_W +: LWS_LANE_W] <= wbuf.data[i*LWS_LANE_W +: LWS_LANE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path with forwarding
    // ------------------------------------------------------------
    logic [LWS_DATA_W-1:0] array_word;
    logic [LWS_DATA_W-1:0] merged;
    logic hit;

    assign array_word = mem[req.addr];
    assign hit = wbuf.valid && (wbuf.addr == req.addr); // see RL16

    genvar g;
    generate
        for (g = 0; g < LWS_LANES; g++)
        begin : g_lane
            lws_lane_merge u_merge
            (
                .array_in(array_word[g*LWS_LANE_W +: LWS_LANE_W]),
                .buffer_in(wbuf.data[g*LWS_LANE_W +: LWS_LANE_W]),
                .use_buffer_in(hit && wbuf.lanes[g]), // see RL16
                .lane_out(merged[g*LWS_LANE_W +: LWS_LANE_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Output register and driver control
    // ------------------------------------------------------------
    logic [LWS_DATA_W-1:0] next_data_out;
    logic next_data_oe_out;
    logic wr_now;

    // A write sampled now releases the drivers on this same edge.
    assign wr_now = !select_n_in && !sync_write_n_in; // see RL7

    always_comb
    begin
        next_data_out = data_out;
        next_data_oe_out = data_oe_out;
        case (cyc)
            LWS_READ:
            begin
                // All lanes return regardless of the byte enables.
                next_data_out = merged; // see RL2, RL3, RL10, RL5
                next_data_oe_out = 1'b1;
            end
            LWS_DESEL:
            begin
                next_data_oe_out = 1'b0; // see RL6
            end
            LWS_WRITE, LWS_NOP_WRITE:
            begin
                next_data_oe_out = 1'b0; // see RL12, RL13
            end
            default:
            begin
                next_data_oe_out = 1'b0;
            end
        endcase
        if (wr_now)
        begin
            next_data_oe_out = 1'b0; // see RL7
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            data_out <= LWS_DATA_ZERO;
            data_oe_out <= 1'b0;
        end
        else
        begin
            data_out <= next_data_out;
            data_oe_out <= next_data_oe_out;
        end
    end
endmodule

// *** testbench/lws_sram_core_sva.sv ***
// Checker with timing assertions for the late-write SRAM core.
`timescale 1ns/1ns
module lws_sram_core_sva
    import lws_pkg::*;
(
    // Watched ports
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [LWS_ADDR_W-1:0] addr_in,
    input wire logic select_n_in,
    input wire logic sync_write_n_in,
    input wire logic [LWS_LANES-1:0] byte_lane_we_n_in,
    input wire logic [LWS_DATA_W-1:0] data_in,
    input wire logic [LWS_DATA_W-1:0] data_out,
    input wire logic data_oe_out
);
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    logic rd;
    logic wr;
    assign rd = !select_n_in && sync_write_n_in;
    assign wr = !select_n_in && !sync_write_n_in;
    property p_wr_off; wr |=> !data_oe_out; endproperty
    a_wr_off: assert property (p_wr_off) else $error("outputs on after write");
    property p_desel; rd ##1 select_n_in |=> data_oe_out ##1 !data_oe_out; endproperty
    a_desel: assert property (p_desel) else $error("deselect timing wrong");
    property p_hold; !rd |-> ##2 $stable(data_out); endproperty
    a_hold: assert property (p_hold) else $error("data changed without read");
    property p_rr; rd ##1 rd |=> data_oe_out ##1 data_oe_out; endproperty
    a_rr: assert property (p_rr) else $error("back to back reads broken");
    property p_wr_rd; wr ##1 rd ##1 !wr |=> data_oe_out; endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read after write lost");
    property p_nop; wr && (&byte_lane_we_n_in) |=> !data_oe_out ##1 $stable(data_out); endproperty
    a_nop: assert property (p_nop) else $error("empty write misbehaved");
    property p_same; rd ##1 (rd && $stable(addr_in)) |=> ##1 $stable(data_out); endproperty
    a_same: assert property (p_same) else $error("repeated read differs");
    property p_off; select_n_in ##1 select_n_in |=> !data_oe_out; endproperty
    a_off: assert property (p_off) else $error("outputs on while deselected");
    property p_fwd;
        (wr && (byte_lane_we_n_in == LWS_NO_LANE)) ##1 (rd && (addr_in == $past(addr_in)))
            |=> ##1 (data_out == $past(data_in, 2));
    endproperty
    a_fwd: assert property (p_fwd) else $error("buffered word not forwarded");
endmodule
bind lws_sram_core lws_sram_core_sva chk_u (.clk_sys_in, .reset_n_in, .addr_in, .select_n_in,
    .sync_write_n_in, .byte_lane_we_n_in, .data_in, .data_out, .data_oe_out);

// *** testbench/lws_ctrl_model.sv ***
// Controller model that drives requests and late write data.
`timescale 1ns/1ns
module lws_ctrl_model
    import lws_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Bus
    output lws_req_t req_out,
    output logic [LWS_DATA_W-1:0] data_out
);
    logic late_pend = 1'b0;
    logic [LWS_DATA_W-1:0] late_data;
    initial req_out = {1'b1, 1'b1, 4'hF, LWS_ADDR_ZERO};
    initial data_out = LWS_DATA_ZERO;
    // Outside write data cycles the data lines toggle so stale values never pass.
    task automatic issue(input lws_cycle_t kind, input logic [LWS_LANES-1:0] lanes_n,
        input logic [LWS_ADDR_W-1:0] addr, input logic [LWS_DATA_W-1:0] wdata);
        @(negedge clk_sys_in);
        data_out = late_pend ? late_data : ~data_out;
        req_out = {kind == LWS_DESEL, !kind[1], lanes_n, addr};
        late_pend = kind[1];
        late_data = wdata;
    endtask
endmodule

// *** testbench/lws_sram_core_tb.sv ***
// Self-checking testbench for the late-write SRAM core.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: %h", $time, (a)); end end
module lws_sram_core_tb
    import lws_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    lws_req_t req;
    logic [LWS_DATA_W-1:0] wdata;
    logic [LWS_DATA_W-1:0] data_out;
    logic data_oe_out;
    logic [LWS_DATA_W-1:0] ref_mem [8];
    lws_cycle_t k1 = LWS_DESEL;
    lws_cycle_t k2 = LWS_DESEL;
    lws_cycle_t kind;
    logic [LWS_DATA_W-1:0] e1;
    logic [LWS_DATA_W-1:0] e2;
    logic [31:0] r;
    int seed = 32'hf5de;
    int bad_count = 0;
    int check_count = 0;
    initial forever #(LWS_CLK_PERIOD_NS / 2.0) clk_sys_in = ~clk_sys_in;
    lws_ctrl_model ctl_u (.clk_sys_in, .req_out(req), .data_out(wdata));
    lws_sram_core dut_u (.clk_sys_in, .reset_n_in, .addr_in(req.addr), .select_n_in(req.select_n),
        .sync_write_n_in(req.sync_write_n), .byte_lane_we_n_in(req.byte_lane_we_n), .data_in(wdata),
        .data_out, .data_oe_out);
    function automatic logic [LWS_DATA_W-1:0] merge(input logic [LWS_DATA_W-1:0] old,
        input logic [LWS_DATA_W-1:0] nw, input logic [LWS_LANES-1:0] lanes_n);
        merge = old;
        for (int i = 0; i < LWS_LANES; i++)
            if (!lanes_n[i]) merge[i*LWS_LANE_W +: LWS_LANE_W] = nw[i*LWS_LANE_W +: LWS_LANE_W];
    endfunction
    // Slot seven stands for the top address of the array.
    task automatic step(input lws_cycle_t kd, input logic [3:0] ln, input logic [2:0] s, input logic [35:0] d);
        ctl_u.issue(kd, ln, (s == 3'h7) ? 10'h3FF : {7'h0, s}, d);
        `CHK(data_oe_out, !k1[1] && k2 == LWS_READ)
        if (k2 == LWS_READ) `CHK(data_out, e2)
        if (kd[1]) ref_mem[s] = merge(ref_mem[s], d, ln);
        k2 = k1;
        e2 = e1;
        k1 = kd;
        e1 = ref_mem[s];
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        for (int i = 0; i < 8; i++) step(LWS_WRITE, 4'h0, i[2:0], {$random(seed), 4'hA});
        step(LWS_READ, 4'hF, 3'h5, LWS_DATA_ZERO);
        step(LWS_DESEL, 4'h0, 3'h5, LWS_DATA_ZERO);
        step(LWS_WRITE, 4'hD, 3'h5, {$random(seed), 4'h3});
        step(LWS_WRITE, 4'h7, 3'h5, {$random(seed), 4'h5});
        step(LWS_READ, 4'h0, 3'h5, LWS_DATA_ZERO);
        step(LWS_DESEL, 4'h0, 3'h5, LWS_DATA_ZERO);
        step(LWS_NOP_WRITE, 4'hF, 3'h5, {$random(seed), 4'h6});
        step(LWS_READ, 4'h5, 3'h5, LWS_DATA_ZERO);
        step(LWS_DESEL, 4'h0, 3'h2, LWS_DATA_ZERO);
        step(LWS_WRITE, 4'h0, 3'h2, {$random(seed), 4'h9});
        step(LWS_READ, 4'hA, 3'h2, LWS_DATA_ZERO);
        repeat (2500)
        begin
            r = $random(seed);
            kind = lws_cycle_t'(r[1:0]);
            if (kind[1] && k1 == LWS_READ) kind = LWS_DESEL;
            step(kind, (kind == LWS_NOP_WRITE) ? 4'hF : r[5:2], r[8:6], {$random(seed), r[12:9]});
        end
        repeat (2) step(LWS_DESEL, 4'hF, 3'h0, LWS_DATA_ZERO);
        give_verdict();
    end
endmodule
